// ==== logic/periph_shell.sv ====
// generic peripheral shell: tasks, events, shortcuts, publish/subscribe, interrupt, pin select
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module periph_shell #(
    parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
    // clock and reset
    input  wire logic                                      i_core_clk,
    input  wire logic                                      i_rst_b,
    // register bus
    input  wire shell_pkg::avs_req_t                       i_avs_req,
    output      shell_pkg::avs_rsp_t                       o_avs_rsp,
    // peripheral core and interconnect
    input  wire logic [shell_pkg::N_EVT-1:0]               i_event_pulse,
    input  wire logic [shell_pkg::N_TASK-1:0]              i_task_pulse,
    input  wire logic [shell_pkg::N_CHAN-1:0]              i_chan_pulse,
    output      logic [shell_pkg::N_TASK-1:0]              o_task_trig,
    output      logic [shell_pkg::N_CHAN-1:0]              o_chan_pulse,
    // system
    input  wire logic                                      i_shared_enabled,
    input  wire logic                                      i_sys_off,
    output      logic                                      o_enabled,
    output      shell_pkg::pin_sel_t                       o_pin_sel,
    output      logic                                      o_irq,
    output      logic [shell_pkg::ID_W-1:0]                o_irq_index
);

    localparam logic [31:0] ID_FULL = (BASE_ADDR - shell_pkg::WIN0_BASE) / shell_pkg::WIN_BYTES;
    localparam logic [shell_pkg::ID_W-1:0] ID = ID_FULL[shell_pkg::ID_W-1:0];

    localparam shell_pkg::state_t RST_ST = '{waitreq: 1'b1, irq_num: ID, default: '0};

    shell_pkg::state_t st_ff;
    shell_pkg::state_t nxt_st;

    logic [11:0]                   byte_addr;
    logic [1:0]                    idx;
    logic [31:0]                   wmask;
    logic [31:0]                   set_bits;
    logic                          req;
    logic                          take;
    logic                          wr;
    shell_pkg::pin_sel_t           pin_live;

    function automatic logic in_grp(input logic [11:0] a, input logic [11:0] base);
        return a[11:4] == base[11:4];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    function automatic logic hit(input shell_pkg::chan_sel_t s, input logic [shell_pkg::N_CHAN-1:0] ch);
        return s.en & ch[s.ch];
    endfunction

    function automatic logic [31:0] sel_word(input shell_pkg::chan_sel_t s);
        return {s.en, 27'h000_0000, s.ch};
    endfunction

    // word index covers exactly 1024 slots of the 4 KB window
    assign byte_addr = {i_avs_req.address, 2'b00};
    assign idx       = byte_addr[3:2];
    assign wmask     = {{8{i_avs_req.byteenable[3]}}, {8{i_avs_req.byteenable[2]}},
                        {8{i_avs_req.byteenable[1]}}, {8{i_avs_req.byteenable[0]}}};
    assign set_bits  = i_avs_req.writedata & wmask;
    assign req       = i_avs_req.read | i_avs_req.write;
    // one wait cycle: data is prepared while waitrequest is high, taken when it drops
    assign take      = req & ~st_ff.waitreq;
    assign wr        = take & i_avs_req.write;
    assign pin_live  = st_ff.enable ? st_ff.psel_cap : '0;

    always_comb
    begin
        logic [31:0]                  rd;
        logic [31:0]                  w;
        logic [shell_pkg::N_EVT-1:0]  ev_pulse;
        logic [shell_pkg::N_EVT-1:0]  ev_clr;
        logic [shell_pkg::N_TASK-1:0] trig;
        logic [shell_pkg::N_CHAN-1:0] pub;
        rd       = shell_pkg::RST_WORD;
        w        = shell_pkg::RST_WORD;
        ev_clr   = '0;
        trig     = '0;
        pub      = '0;
        nxt_st   = st_ff;
        ev_pulse = i_event_pulse & {shell_pkg::N_EVT{st_ff.enable}};

        // read decode; unmapped words read as zero
        if (in_grp(byte_addr, shell_pkg::SUB_OFS))
        begin
            rd = sel_word(st_ff.sub[idx]);
        end
        else if (in_grp(byte_addr, shell_pkg::EVT_OFS))
        begin
            rd = {31'h0000_0000, st_ff.events[idx]};
        end
        else if (in_grp(byte_addr, shell_pkg::PUB_OFS))
        begin
            rd = sel_word(st_ff.pub[idx]);
        end
        else if (byte_addr == shell_pkg::SHORT_OFS)
        begin
            rd = {28'h000_0000, st_ff.shorts};
        end
        else if (byte_addr == shell_pkg::IRQ_EN_OFS || byte_addr == shell_pkg::INTSET_OFS
                 || byte_addr == shell_pkg::INTCLR_OFS)
        begin
            rd = {28'h000_0000, st_ff.irq_en};
        end
        else if (byte_addr == shell_pkg::ENABLE_OFS)
        begin
            rd = {31'h0000_0000, st_ff.enable};
        end
        else if (byte_addr == shell_pkg::PSEL_OFS)
        begin
            rd = {st_ff.psel.connect, 25'h000_0000, st_ff.psel.pin};
        end

        nxt_st.waitreq = ~(req & st_ff.waitreq);
        if (req & st_ff.waitreq)
        begin
            nxt_st.rdata = rd;
        end

        if (wr)
        begin
            if (in_grp(byte_addr, shell_pkg::TASK_OFS))
            begin
                trig[idx] = i_avs_req.writedata[0] & i_avs_req.byteenable[0];
            end
            else if (in_grp(byte_addr, shell_pkg::SUB_OFS))
            begin
                w = merge(sel_word(st_ff.sub[idx]), i_avs_req.writedata, wmask);
                nxt_st.sub[idx] = '{en: w[31], ch: w[shell_pkg::CH_W-1:0]};
            end
            else if (in_grp(byte_addr, shell_pkg::EVT_OFS))
            begin
                // only a zero clears; writing one does not fake an event
                ev_clr[idx] = ~i_avs_req.writedata[0] & i_avs_req.byteenable[0];
            end
            else if (in_grp(byte_addr, shell_pkg::PUB_OFS))
            begin
                w = merge(sel_word(st_ff.pub[idx]), i_avs_req.writedata, wmask);
                nxt_st.pub[idx] = '{en: w[31], ch: w[shell_pkg::CH_W-1:0]};
            end
            else if (byte_addr == shell_pkg::SHORT_OFS)
            begin
                w = merge({28'h000_0000, st_ff.shorts}, i_avs_req.writedata, wmask);
                nxt_st.shorts = w[shell_pkg::N_EVT-1:0];
            end
            else if (byte_addr == shell_pkg::IRQ_EN_OFS)
            begin
                w = merge({28'h000_0000, st_ff.irq_en}, i_avs_req.writedata, wmask);
                nxt_st.irq_en = w[shell_pkg::N_EVT-1:0];
            end
            else if (byte_addr == shell_pkg::INTSET_OFS)
            begin
                nxt_st.irq_en = st_ff.irq_en | set_bits[shell_pkg::N_EVT-1:0];
            end
            else if (byte_addr == shell_pkg::INTCLR_OFS)
            begin
                nxt_st.irq_en = st_ff.irq_en & ~set_bits[shell_pkg::N_EVT-1:0];
            end
            else if (byte_addr == shell_pkg::ENABLE_OFS && i_avs_req.byteenable[0])
            begin
                // a sibling on the same identifier already owns the window
                if (!(i_avs_req.writedata[0] && !st_ff.enable && i_shared_enabled && ID != '0))
                begin
                    nxt_st.enable = i_avs_req.writedata[0];
                end
            end
            else if (byte_addr == shell_pkg::PSEL_OFS)
            begin
                w = merge({st_ff.psel.connect, 25'h000_0000, st_ff.psel.pin}, i_avs_req.writedata, wmask);
                nxt_st.psel = '{connect: w[31], pin: w[shell_pkg::PIN_W-1:0]};
            end
        end

        // pulses fan out regardless of the event register level
        for (int e = 0; e < shell_pkg::N_EVT; e++)
        begin
            for (int c = 0; c < shell_pkg::N_CHAN; c++)
            begin
                if (ev_pulse[e] && st_ff.pub[e].en && st_ff.pub[e].ch == c[shell_pkg::CH_W-1:0])
                begin
                    pub[c] = 1'b1;
                end
            end
        end
        for (int t = 0; t < shell_pkg::N_TASK; t++)
        begin
            trig[t] = trig[t] | i_task_pulse[t] | hit(st_ff.sub[t], i_chan_pulse)
                      | (ev_pulse[t] & st_ff.shorts[t]);
        end
        nxt_st.task_trig  = trig & {shell_pkg::N_TASK{st_ff.enable}};
        nxt_st.chan_pulse = pub;

        // set wins over a clear landing in the same cycle
        nxt_st.events = (st_ff.events & ~ev_clr) | ev_pulse;

        // the pin only follows the register while disabled; delay line gives the four cycles
        nxt_st.psel_cap  = nxt_st.enable ? st_ff.psel_cap : nxt_st.psel;
        nxt_st.psel_pipe = {st_ff.psel_pipe[shell_pkg::PSEL_DELAY-2:0], pin_live};

        nxt_st.irq     = |(nxt_st.events & nxt_st.irq_en);
        nxt_st.irq_num = ID;

        if (i_sys_off)
        begin
            nxt_st         = RST_ST;
            nxt_st.waitreq = ~(req & st_ff.waitreq);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_ff <= RST_ST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_avs_rsp.readdata    = st_ff.rdata;
    assign o_avs_rsp.waitrequest = st_ff.waitreq;
    assign o_task_trig           = st_ff.task_trig;
    assign o_chan_pulse          = st_ff.chan_pulse;
    assign o_enabled             = st_ff.enable;
    assign o_pin_sel             = st_ff.psel_pipe[shell_pkg::PSEL_DELAY-1];
    assign o_irq                 = st_ff.irq;
    assign o_irq_index           = st_ff.irq_num;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    irq_level_a: assert property (
        (st_ff.enable && |(i_event_pulse & st_ff.irq_en) && !wr && !i_sys_off) |=> o_irq)
        else $error("enabled event did not raise the interrupt");

    wait_cycle_a: assert property (
        (req && st_ff.waitreq) |=> !o_avs_rsp.waitrequest ##1 o_avs_rsp.waitrequest)
        else $error("bus answer not exactly one wait cycle");

    event_set_a: assert property (
        (st_ff.enable && i_event_pulse[0] && !i_sys_off) |=> st_ff.events[0] [*1] ##0 (st_ff.events[0]))
        else $error("event pulse did not set its register");

    event_sticky_a: assert property (
        (st_ff.events[2] && !i_sys_off
         && !(wr && in_grp(byte_addr, shell_pkg::EVT_OFS) && idx == 2'd2 && !i_avs_req.writedata[0]))
        |=> st_ff.events[2])
        else $error("event register dropped without a software clear");

    disabled_quiet_a: assert property (
        (!st_ff.enable && !wr) |=> (o_task_trig == '0 && o_chan_pulse == '0))
        else $error("task or publish activity while disabled");

    pin_delay_a: assert property (
        (!i_sys_off) [*4] |=> o_pin_sel == $past(pin_live, 4))
        else $error("pin selection not applied after four cycles");

    shared_refuse_a: assert property (
        (wr && byte_addr == shell_pkg::ENABLE_OFS && i_avs_req.writedata[0] && i_shared_enabled
         && !st_ff.enable && ID != '0) |=> !o_enabled)
        else $error("enable accepted while sibling enabled");

    set_alias_a: assert property (
        (wr && byte_addr == shell_pkg::INTSET_OFS && !i_sys_off)
        |=> ((st_ff.irq_en & $past(set_bits[3:0])) == $past(set_bits[3:0])))
        else $error("set alias did not set mask bits");

    clear_alias_a: assert property (
        (wr && byte_addr == shell_pkg::INTCLR_OFS && !i_sys_off)
        |=> ((st_ff.irq_en & $past(set_bits[3:0])) == 4'h0))
        else $error("clear alias did not clear mask bits");

    alias_read_a: assert property (
        (req && st_ff.waitreq && i_avs_req.read && byte_addr == shell_pkg::INTCLR_OFS && !i_sys_off)
        |=> o_avs_rsp.readdata == {28'h000_0000, $past(st_ff.irq_en)})
        else $error("clear alias read does not return the mask");

    set_read_a: assert property (
        (req && st_ff.waitreq && i_avs_req.read && byte_addr == shell_pkg::INTSET_OFS && !i_sys_off)
        |=> o_avs_rsp.readdata == {28'h000_0000, $past(st_ff.irq_en)})
        else $error("set alias read does not return the mask");

    unmapped_read_a: assert property (
        (req && st_ff.waitreq && i_avs_req.read && byte_addr == 12'hffc)
        |=> o_avs_rsp.readdata == 32'h0000_0000)
        else $error("unmapped word did not read as zero");

    wait_idle_a: assert property (
        (!req && st_ff.waitreq) |=> o_avs_rsp.waitrequest)
        else $error("waitrequest dropped without a request");

    sys_off_clear_a: assert property (
        i_sys_off |=> (st_ff.irq_en == '0 && st_ff.events == '0 && st_ff.shorts == '0
                       && !o_enabled && !o_irq && o_task_trig == '0))
        else $error("system-off left a register set");

    task_write_a: assert property (
        (wr && in_grp(byte_addr, shell_pkg::TASK_OFS) && idx == 2'd1 && i_avs_req.writedata[0]
         && i_avs_req.byteenable[0] && st_ff.enable && !i_sys_off) |=> o_task_trig[1])
        else $error("task register write did not trigger");

    task_pin_a: assert property (
        (st_ff.enable && i_task_pulse[3] && !i_sys_off)
        |=> o_task_trig[3])
        else $error("task input pulse did not trigger");

    shortcut_fire_a: assert property (
        (st_ff.enable && i_event_pulse[0] && st_ff.shorts[0] && !i_sys_off)
        |=> o_task_trig[0])
        else $error("enabled shortcut did not trigger its task");

    publish_fire_a: assert property (
        (st_ff.enable && i_event_pulse[0] && st_ff.pub[0].en && !wr && !i_sys_off)
        |=> o_chan_pulse[st_ff.pub[0].ch])
        else $error("event pulse not published");

    subscribe_fire_a: assert property (
        (st_ff.enable && st_ff.sub[2].en && i_chan_pulse[st_ff.sub[2].ch] && !i_sys_off)
        |=> o_task_trig[2])
        else $error("subscribed channel did not trigger its task");

    event_clear_a: assert property (
        (wr && in_grp(byte_addr, shell_pkg::EVT_OFS) && idx == 2'd2 && !i_avs_req.writedata[0]
         && i_avs_req.byteenable[0] && !(st_ff.enable && i_event_pulse[2])) |=> !st_ff.events[2])
        else $error("zero write did not clear the event");

    pin_hold_a: assert property (
        (st_ff.enable && !(wr && byte_addr == shell_pkg::ENABLE_OFS) && !i_sys_off)
        |=> $stable(st_ff.psel_cap))
        else $error("pin selection moved while enabled");

    disable_write_a: assert property (
        (wr && byte_addr == shell_pkg::ENABLE_OFS && i_avs_req.byteenable[0] && !i_avs_req.writedata[0])
        |=> !o_enabled)
        else $error("disable write did not take effect");

    irq_drop_a: assert property (
        (!(|(st_ff.events & st_ff.irq_en)) && !wr && !(st_ff.enable && |i_event_pulse))
        |=> !o_irq)
        else $error("interrupt raised with no enabled event");

endmodule

// ==== logic/shell_pkg.sv ====
// shared constants and carriers of the peripheral register shell
package shell_pkg;

    localparam int          N_EVT       = 4;
    localparam int          N_TASK      = 4;
    localparam int          N_CHAN      = 16;
    localparam int          CH_W        = 4;
    localparam int          PIN_W       = 6;
    localparam int          ID_W        = 8;
    localparam int          ADDR_W      = 10;
    localparam int          PSEL_DELAY  = 4;

    localparam logic [31:0] WIN0_BASE   = 32'h4000_0000;
    localparam logic [31:0] WIN_BYTES   = 32'h0000_1000;

    // byte offsets inside the window; the task, subscribe, event and publish groups are four consecutive words each
    localparam logic [11:0] TASK_OFS    = 12'h000;
    localparam logic [11:0] SUB_OFS     = 12'h080;
    localparam logic [11:0] EVT_OFS     = 12'h100;
    localparam logic [11:0] PUB_OFS     = 12'h180;
    localparam logic [11:0] SHORT_OFS   = 12'h200;
    localparam logic [11:0] IRQ_EN_OFS  = 12'h300;
    localparam logic [11:0] INTSET_OFS  = 12'h304;
    localparam logic [11:0] INTCLR_OFS  = 12'h308;
    localparam logic [11:0] ENABLE_OFS  = 12'h500;
    localparam logic [11:0] PSEL_OFS    = 12'h508;

    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    typedef struct packed {
        logic              en;
        logic [CH_W-1:0]   ch;
    } chan_sel_t;

    typedef struct packed {
        logic              connect;
        logic [PIN_W-1:0]  pin;
    } pin_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avs_req_t;

    typedef struct packed {
        logic [31:0]       readdata;
        logic              waitrequest;
    } avs_rsp_t;

    typedef struct packed {
        logic                              waitreq;
        logic [31:0]                       rdata;
        logic                              enable;
        pin_sel_t                          psel;
        pin_sel_t                          psel_cap;
        pin_sel_t [PSEL_DELAY-1:0]         psel_pipe;
        logic [N_EVT-1:0]                  irq_en;
        logic [N_EVT-1:0]                  events;
        logic [N_EVT-1:0]                  shorts;
        chan_sel_t [N_TASK-1:0]            sub;
        chan_sel_t [N_EVT-1:0]             pub;
        logic [N_TASK-1:0]                 task_trig;
        logic [N_CHAN-1:0]                 chan_pulse;
        logic                              irq;
        logic [ID_W-1:0]                   irq_num;
    } state_t;

endpackage

// ==== verification/cpu_bus_model.sv ====
// cpu side master model for the shell's register bus
`timescale 1ns/10ps
module cpu_bus_model (
    // clock
    input  wire logic                 i_core_clk,
    // register bus
    input  wire shell_pkg::avs_rsp_t  i_avs_rsp,
    output      shell_pkg::avs_req_t  o_avs_req
);
    initial o_avs_req = '0;

    // request held until waitrequest is seen low at a rising edge; no latency is assumed
    task automatic access(input logic wr, input logic [11:0] ofs, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        o_avs_req <= '{address: ofs[11:2], read: !wr, write: wr, writedata: wdata, byteenable: 4'hf};
        do
            @(posedge i_core_clk);
        while (i_avs_rsp.waitrequest !== 1'b0);
        rdata = i_avs_rsp.readdata;
        o_avs_req <= '0;
        // idle edge so a following call never drives the strobe twice in one step
        @(posedge i_core_clk);
    endtask
endmodule

// ==== verification/tb_periph_shell.sv ====
// self-checking bench of the peripheral register shell
`timescale 1ns/10ps
module tb_periph_shell;
    localparam logic [31:0] BASE = 32'h4000_3000;

    logic                 i_core_clk;
    logic                 i_rst_b;
    shell_pkg::avs_req_t  avs_req;
    shell_pkg::avs_rsp_t  avs_rsp;
    logic [3:0]           event_pulse;
    logic [3:0]           task_pulse;
    logic [3:0]           task_trig;
    logic [15:0]          chan_in;
    logic [15:0]          chan_out;
    logic                 shared_en;
    logic                 sys_off;
    logic                 enabled;
    logic                 irq;
    shell_pkg::pin_sel_t  pin_sel;
    logic [7:0]           irq_index;
    logic                 clr_cnt;
    logic [31:0]          rdata;
    int                   fail_count;
    int                   check_count;
    int                   trig_cnt [4];
    int                   chan_cnt [16];

    cpu_bus_model i_cpu_bus_model (.i_core_clk(i_core_clk), .i_avs_rsp(avs_rsp), .o_avs_req(avs_req));

    periph_shell #(.BASE_ADDR(BASE)) i_periph_shell (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_avs_req(avs_req), .o_avs_rsp(avs_rsp),
        .i_event_pulse(event_pulse), .i_task_pulse(task_pulse), .i_chan_pulse(chan_in),
        .o_task_trig(task_trig), .o_chan_pulse(chan_out), .i_shared_enabled(shared_en),
        .i_sys_off(sys_off), .o_enabled(enabled), .o_pin_sel(pin_sel), .o_irq(irq),
        .o_irq_index(irq_index));

    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // counting pulses shows both that a trigger came and that it lasted one cycle
    always @(posedge i_core_clk)
    begin
        for (int k = 0; k < 4; k++)
            trig_cnt[k] <= clr_cnt ? 0 : trig_cnt[k] + int'(task_trig[k] === 1'b1);
        for (int k = 0; k < 16; k++)
            chan_cnt[k] <= clr_cnt ? 0 : chan_cnt[k] + int'(chan_out[k] === 1'b1);
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
        i_cpu_bus_model.access(1'b0, ofs, 32'h0000_0000, rdata);
        check(rdata, exp);
    endtask

    task automatic wr(input logic [11:0] ofs, input logic [31:0] data);
        i_cpu_bus_model.access(1'b1, ofs, data, rdata);
    endtask

    task automatic pulse_evt(input int n);
        event_pulse[n] <= 1'b1;
        @(posedge i_core_clk);
        event_pulse <= 4'h0;
        repeat (4) @(posedge i_core_clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge i_core_clk);
        fail_count++;
        summarize();
    end

    initial
    begin
        i_rst_b = 1'b0;
        event_pulse = 4'h0;
        task_pulse = 4'h0;
        chan_in = 16'h0000;
        shared_en = 1'b0;
        sys_off = 1'b0;
        clr_cnt = 1'b1;
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        clr_cnt <= 1'b0;
        @(posedge i_core_clk);
        check(32'(irq_index), (BASE - shell_pkg::WIN0_BASE) / shell_pkg::WIN_BYTES);
        rd(shell_pkg::ENABLE_OFS, 32'h0000_0000);
        wr(12'hffc, 32'hffff_ffff);
        rd(12'hffc, 32'h0000_0000);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0000);
        $display("test reset_and_window done");

        wr(shell_pkg::INTSET_OFS, 32'h0000_0005);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0005);
        rd(shell_pkg::INTSET_OFS, 32'h0000_0005);
        wr(shell_pkg::INTCLR_OFS, 32'h0000_0001);
        rd(shell_pkg::INTCLR_OFS, 32'h0000_0004);
        wr(shell_pkg::INTSET_OFS, 32'h0000_0000);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0004);
        $display("test set_clear_alias done");

        wr(shell_pkg::PUB_OFS, 32'h8000_0005);
        wr(shell_pkg::SUB_OFS + 12'h008, 32'h8000_0007);
        wr(shell_pkg::SHORT_OFS, 32'h0000_0001);
        rd(shell_pkg::PUB_OFS, 32'h8000_0005);
        pulse_evt(0);
        wr(shell_pkg::TASK_OFS + 12'h004, 32'h0000_0001);
        rd(shell_pkg::EVT_OFS, 32'h0000_0000);
        check(32'(trig_cnt[0] + trig_cnt[1] + chan_cnt[5]), 32'h0000_0000);
        $display("test disabled_ignores done");

        wr(shell_pkg::ENABLE_OFS, 32'h0000_0001);
        check(32'(enabled), 32'h0000_0001);
        pulse_evt(0);
        pulse_evt(0);
        rd(shell_pkg::EVT_OFS, 32'h0000_0001);
        check(32'(trig_cnt[0]), 32'h0000_0002);
        check(32'(chan_cnt[5]), 32'h0000_0002);
        check(32'(irq), 32'h0000_0000);
        wr(shell_pkg::TASK_OFS + 12'h004, 32'h0000_0001);
        task_pulse <= 4'h8;
        chan_in <= 16'h0080;
        @(posedge i_core_clk);
        task_pulse <= 4'h0;
        chan_in <= 16'h0000;
        repeat (4) @(posedge i_core_clk);
        check(32'(trig_cnt[1]), 32'h0000_0001);
        check(32'(trig_cnt[3]), 32'h0000_0001);
        check(32'(trig_cnt[2]), 32'h0000_0001);
        $display("test tasks_events done");

        pulse_evt(2);
        check(32'(irq), 32'h0000_0001);
        wr(shell_pkg::EVT_OFS + 12'h008, 32'h0000_0001);
        rd(shell_pkg::EVT_OFS + 12'h008, 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        wr(shell_pkg::EVT_OFS + 12'h008, 32'h0000_0000);
        rd(shell_pkg::EVT_OFS + 12'h008, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        $display("test interrupt done");

        wr(shell_pkg::ENABLE_OFS, 32'h0000_0000);
        wr(shell_pkg::PSEL_OFS, 32'h8000_0015);
        repeat (6) @(posedge i_core_clk);
        check(32'(pin_sel), 32'h0000_0000);
        wr(shell_pkg::ENABLE_OFS, 32'h0000_0001);
        check(32'(pin_sel), 32'h0000_0000);
        repeat (5) @(posedge i_core_clk);
        check(32'(pin_sel), 32'h0000_0055);
        wr(shell_pkg::PSEL_OFS, 32'h8000_0003);
        repeat (6) @(posedge i_core_clk);
        check(32'(pin_sel), 32'h0000_0055);
        wr(shell_pkg::ENABLE_OFS, 32'h0000_0000);
        wr(shell_pkg::ENABLE_OFS, 32'h0000_0001);
        repeat (6) @(posedge i_core_clk);
        check(32'(pin_sel), 32'h0000_0043);
        $display("test pin_select done");

        wr(shell_pkg::ENABLE_OFS, 32'h0000_0000);
        wr(shell_pkg::PSEL_OFS, 32'h0000_0000);
        wr(shell_pkg::PUB_OFS, 32'h0000_0000);
        wr(shell_pkg::INTCLR_OFS, 32'hffff_ffff);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0000);
        rd(shell_pkg::PSEL_OFS, 32'h0000_0000);
        shared_en <= 1'b1;
        wr(shell_pkg::ENABLE_OFS, 32'h0000_0001);
        rd(shell_pkg::ENABLE_OFS, 32'h0000_0000);
        shared_en <= 1'b0;
        wr(shell_pkg::INTSET_OFS, 32'h0000_0003);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0003);
        sys_off <= 1'b1;
        @(posedge i_core_clk);
        sys_off <= 1'b0;
        @(posedge i_core_clk);
        rd(shell_pkg::IRQ_EN_OFS, 32'h0000_0000);
        rd(shell_pkg::SHORT_OFS, 32'h0000_0000);
        rd(shell_pkg::SUB_OFS + 12'h008, 32'h0000_0000);
        wr(shell_pkg::SHORT_OFS, 32'h0000_0001);
        rd(shell_pkg::SHORT_OFS, 32'h0000_0001);
        // second reset in mid-run must clear what system-off cleared
        i_rst_b <= 1'b0;
        @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        rd(shell_pkg::SHORT_OFS, 32'h0000_0000);
        check(32'(irq_index), (BASE - shell_pkg::WIN0_BASE) / shell_pkg::WIN_BYTES);
        $display("test shared_and_sysoff done");
        summarize();
    end
endmodule
